//--- rtl/ebt_pkg.sv
// constants and the state record for the eight-bit trigger timer
package ebt_pkg;
  // ==========================================================
  // register offsets on the plain register port
  localparam int           ADDR_W     = 3;
  localparam logic [2:0]   ADDR_CNT   = 3'h0;
  localparam logic [2:0]   ADDR_CMPA  = 3'h1;
  localparam logic [2:0]   ADDR_CMPB  = 3'h2;
  localparam logic [2:0]   ADDR_CTRL0 = 3'h3;
  localparam logic [2:0]   ADDR_CTRL1 = 3'h4;
  localparam logic [2:0]   ADDR_CSR   = 3'h5;
  // ==========================================================
  // field positions, first control register
  localparam int           C0_IEB     = 7;
  localparam int           C0_IEA     = 6;
  localparam int           C0_OVERFLOW_IRQ_ENABLE    = 5;
  localparam int           C0_CLR_LO  = 3;
  localparam int           C0_CKS_LO  = 0;
  // field positions, second control register
  localparam int           C1_EDG_LO  = 3;
  localparam int           C1_TRIGGER_START_ENABLE    = 2;
  localparam int           C1_ICKS    = 0;
  // field positions, control/status register
  localparam int           CS_MATCH_FLAG_B    = 7;
  localparam int           CS_MATCH_FLAG_A    = 6;
  localparam int           CS_OVF     = 5;
  localparam int           CS_OSB_LO  = 2;
  localparam int           CS_OSA_LO  = 0;
  // ==========================================================
  // reset values, read-as-one and writable masks, counter top
  localparam logic [7:0]   RST_ZERO   = 8'h00;
  localparam logic [7:0]   C1_ONES    = 8'he2;
  localparam logic [7:0]   C1_RW      = 8'h1d;
  localparam logic [7:0]   CS_ONES    = 8'h10;
  localparam logic [7:0]   CNT_TOP    = 8'hff;
  // ==========================================================
  // field encodings
  localparam logic [1:0]   CLR_NONE   = 2'h0;
  localparam logic [1:0]   CLR_MA     = 2'h1;
  localparam logic [1:0]   CLR_MB     = 2'h2;
  localparam logic [1:0]   CLR_PIN    = 2'h3;
  localparam logic [1:0]   EDG_OFF    = 2'h0;
  localparam logic [1:0]   EDG_RISE   = 2'h1;
  localparam logic [1:0]   EDG_FALL   = 2'h2;
  localparam logic [1:0]   OS_KEEP    = 2'h0;
  localparam logic [1:0]   OS_LOW     = 2'h1;
  localparam logic [1:0]   OS_HIGH    = 2'h2;
  localparam logic [1:0]   OS_TOG     = 2'h3;
  localparam int           DIV_W      = 7;
  localparam logic [6:0]   DIV_ONE    = 7'h01;

  // all registered state of the timer
  typedef struct packed {
    logic [7:0]       cnt;     // up counter
    logic [7:0]       cmpa;    // compare value a
    logic [7:0]       cmpb;    // compare value b
    logic [7:0]       ctrl0;   // first control register
    logic [7:0]       ctrl1;   // second control register, writable bits
    logic [7:0]       csr;     // flags and output selects
    logic [2:0]       seen;    // flag read as one since last clear
    logic             run;     // trigger-start gate
    logic             wave;    // waveform output level
    logic [DIV_W-1:0] div;     // free-running system clock divider
    logic             lvl;     // previous selected clock level
    logic [2:0]       trg_s;   // trigger pin synchroniser and history
    logic [2:0]       clr_s;   // clear pin synchroniser and history
    logic [2:0]       ext_s;   // external clock synchroniser and history
    logic [7:0]       rdata;   // read data, one cycle after the strobe
  } ebt_state_t;
endpackage : ebt_pkg

//--- rtl/ebt_timer.sv
// eight-bit trigger timer: counter, two compares, waveform pin, register port
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module ebt_timer (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // register port
  input  wire logic [ebt_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [7:0]                o_rdata,
  // pins
  input  wire logic                      i_trigger_pin,
  input  wire logic                      i_clear_input_pin,
  input  wire logic                      i_ext_clk_pin,
  output logic                           o_waveform_out,
  // interrupt requests
  output logic                           o_ovf_req,
  output logic                           o_match_a_req,
  output logic                           o_match_b_req
);

  // ==========================================================
  // helpers

  // divider bit that carries the selected divided clock
  function automatic logic [2:0] div_bit(input logic [1:0] cks_lo, input logic icks);
    div_bit = 3'({cks_lo, icks} - 3'h1);
  endfunction : div_bit

  // true when a flag bit is to be cleared by this write
  function automatic logic flag_clr(input logic wr, input logic wbit, input logic seen);
    flag_clr = wr & ~wbit & seen;
  endfunction : flag_clr

  // ==========================================================
  // state
  ebt_pkg::ebt_state_t r;        // registered state
  ebt_pkg::ebt_state_t next_r;   // next state

  // decoded control fields
  logic [2:0] cks;               // clock source field
  logic       icks;              // internal divide select
  logic [1:0] clr_sel;           // clear select
  logic [1:0] edg_sel;           // trigger edge select
  logic       trigger_start_enable;              // trigger start enable
  logic [1:0] os_a;              // output action on match a
  logic [1:0] os_b;              // output action on match b
  // write strobes per register
  logic       wr_cnt;
  logic       wr_cmpa;
  logic       wr_cmpb;
  logic       wr_csr;
  // events
  logic       lvl_now;           // selected clock level this cycle
  logic       raw_tick;          // clock edge seen, before gating
  logic       tick;              // increment this cycle
  logic       match_a;           // compare match a event
  logic       match_b;           // compare match b event
  logic       pin_clr;           // clear pin rising edge
  logic       clear;             // counter clear this cycle
  logic       trg_ev;            // selected trigger edge
  logic       ovf_ev;            // wrap from top to zero
  logic       ext_rise;
  logic       ext_fall;
  logic       trg_rise;
  logic       trg_fall;
  logic [7:0] rd_mux;            // read data before registering

  // ==========================================================
  // field decode
  assign cks     = r.ctrl0[ebt_pkg::C0_CKS_LO +: 3];
  assign icks    = r.ctrl1[ebt_pkg::C1_ICKS];
  assign clr_sel = r.ctrl0[ebt_pkg::C0_CLR_LO +: 2];
  assign edg_sel = r.ctrl1[ebt_pkg::C1_EDG_LO +: 2];
  assign trigger_start_enable    = r.ctrl1[ebt_pkg::C1_TRIGGER_START_ENABLE];
  assign os_a    = r.csr[ebt_pkg::CS_OSA_LO +: 2];
  assign os_b    = r.csr[ebt_pkg::CS_OSB_LO +: 2];

  assign wr_cnt  = i_wr & (i_addr == ebt_pkg::ADDR_CNT);
  assign wr_cmpa = i_wr & (i_addr == ebt_pkg::ADDR_CMPA);
  assign wr_cmpb = i_wr & (i_addr == ebt_pkg::ADDR_CMPB);
  assign wr_csr  = i_wr & (i_addr == ebt_pkg::ADDR_CSR);

  // ==========================================================
  // pin edges: only the second and third stages are looked at
  assign ext_rise = r.ext_s[1] & ~r.ext_s[2];
  assign ext_fall = ~r.ext_s[1] & r.ext_s[2];
  assign trg_rise = r.trg_s[1] & ~r.trg_s[2];
  assign trg_fall = ~r.trg_s[1] & r.trg_s[2];
  // a pulse held 1.5 clocks is always caught by the three-stage sampler
  assign pin_clr  = r.clr_s[1] & ~r.clr_s[2];

  // trigger edge decode
  always_comb
  begin
    unique case (edg_sel)
      ebt_pkg::EDG_OFF:  trg_ev = 1'b0;
      ebt_pkg::EDG_RISE: trg_ev = trg_rise;
      ebt_pkg::EDG_FALL: trg_ev = trg_fall;
      default:           trg_ev = trg_rise | trg_fall;
    endcase
  end

  // ==========================================================
  // count clock selection
  // the previous level is kept across source changes on purpose: a switch
  // from a high to a low internal source looks like a falling edge and counts once
  always_comb
  begin
    lvl_now  = 1'b0;
    raw_tick = 1'b0;
    if (!cks[2] && cks[1:0] != 2'h0)
    begin
      // internal divided clock, counted on its falling edge
      lvl_now  = r.div[div_bit(cks[1:0], icks)];
      raw_tick = r.lvl & ~lvl_now;
    end
    else if (cks[2])
    begin
      // external clock pin; code 100 leaves the clock off
      lvl_now = r.ext_s[2];
      unique case (cks[1:0])
        2'h1:    raw_tick = ext_rise;
        2'h2:    raw_tick = ext_fall;
        2'h3:    raw_tick = ext_rise | ext_fall;
        default: raw_tick = 1'b0;
      endcase
    end
  end

  // counting needs no run bit unless the trigger gate is in use
  assign tick = raw_tick & (~trigger_start_enable | r.run);

  // ==========================================================
  // compare, clear and overflow events
  // a match is raised on the increment that leaves the equal value, so it
  // lands in the last state in which counter and compare agree
  assign match_a = tick & (r.cnt == r.cmpa) & ~wr_cmpa;
  assign match_b = tick & (r.cnt == r.cmpb) & ~wr_cmpb;

  always_comb
  begin
    unique case (clr_sel)
      ebt_pkg::CLR_NONE: clear = 1'b0;
      ebt_pkg::CLR_MA:   clear = match_a;
      ebt_pkg::CLR_MB:   clear = match_b;
      default:           clear = pin_clr;
    endcase
  end

  // wrap only when the increment actually happens
  assign ovf_ev = tick & (r.cnt == ebt_pkg::CNT_TOP) & ~clear & ~wr_cnt;

  // ==========================================================
  // read mux
  always_comb
  begin
    unique case (i_addr)
      ebt_pkg::ADDR_CNT:   rd_mux = r.cnt;
      ebt_pkg::ADDR_CMPA:  rd_mux = r.cmpa;
      ebt_pkg::ADDR_CMPB:  rd_mux = r.cmpb;
      ebt_pkg::ADDR_CTRL0: rd_mux = r.ctrl0;
      ebt_pkg::ADDR_CTRL1: rd_mux = r.ctrl1 | ebt_pkg::C1_ONES;
      ebt_pkg::ADDR_CSR:   rd_mux = r.csr | ebt_pkg::CS_ONES;
      default:             rd_mux = ebt_pkg::RST_ZERO;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_r       = r;
    // free-running divider stands in for the shared prescaler
    next_r.div   = r.div + ebt_pkg::DIV_ONE;
    next_r.lvl   = lvl_now;
    // pin samplers: stage 0 feeds stage 1 and nothing else
    next_r.trg_s = {r.trg_s[1:0], i_trigger_pin};
    next_r.clr_s = {r.clr_s[1:0], i_clear_input_pin};
    next_r.ext_s = {r.ext_s[1:0], i_ext_clk_pin};

    // counter: clear, then write, then increment
    if (clear)
      next_r.cnt = ebt_pkg::RST_ZERO;
    else if (wr_cnt)
      next_r.cnt = i_wdata;
    else if (tick)
      next_r.cnt = r.cnt + 8'h01;

    // trigger gate: an edge in the clear cycle restarts the count
    if (trigger_start_enable && trg_ev)
      next_r.run = 1'b1;
    else if (trigger_start_enable && clear)
      next_r.run = 1'b0;

    // plain register writes
    if (wr_cmpa)
      next_r.cmpa = i_wdata;
    if (wr_cmpb)
      next_r.cmpb = i_wdata;
    if (i_wr && i_addr == ebt_pkg::ADDR_CTRL0)
      next_r.ctrl0 = i_wdata;
    if (i_wr && i_addr == ebt_pkg::ADDR_CTRL1)
      next_r.ctrl1 = i_wdata & ebt_pkg::C1_RW;
    if (wr_csr)
      next_r.csr[3:0] = i_wdata[3:0];

    // flags: read-one then write-zero clears; a new event wins
    if (flag_clr(wr_csr, i_wdata[ebt_pkg::CS_MATCH_FLAG_B], r.seen[2]))
      next_r.csr[ebt_pkg::CS_MATCH_FLAG_B] = 1'b0;
    if (flag_clr(wr_csr, i_wdata[ebt_pkg::CS_MATCH_FLAG_A], r.seen[1]))
      next_r.csr[ebt_pkg::CS_MATCH_FLAG_A] = 1'b0;
    if (flag_clr(wr_csr, i_wdata[ebt_pkg::CS_OVF], r.seen[0]))
      next_r.csr[ebt_pkg::CS_OVF] = 1'b0;
    if (match_b)
      next_r.csr[ebt_pkg::CS_MATCH_FLAG_B] = 1'b1;
    if (match_a)
      next_r.csr[ebt_pkg::CS_MATCH_FLAG_A] = 1'b1;
    if (ovf_ev)
      next_r.csr[ebt_pkg::CS_OVF] = 1'b1;

    // remember which flags were read as one; forget once cleared
    if (i_rd && i_addr == ebt_pkg::ADDR_CSR)
      next_r.seen = r.seen | r.csr[7:5];
    next_r.seen = next_r.seen & next_r.csr[7:5];

    // waveform pin: toggle beats high, high beats low
    if ((match_a && os_a == ebt_pkg::OS_TOG) || (match_b && os_b == ebt_pkg::OS_TOG))
      next_r.wave = ~r.wave;
    else if ((match_a && os_a == ebt_pkg::OS_HIGH) || (match_b && os_b == ebt_pkg::OS_HIGH))
      next_r.wave = 1'b1;
    else if ((match_a && os_a == ebt_pkg::OS_LOW) || (match_b && os_b == ebt_pkg::OS_LOW))
      next_r.wave = 1'b0;

    // read data stands only in the cycle after the strobe
    next_r.rdata = i_rd ? rd_mux : ebt_pkg::RST_ZERO;
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r       <= '0;
      r.ctrl1 <= ebt_pkg::RST_ZERO;
    end
    else
      r <= next_r;
  end

  // ==========================================================
  // outputs; the request lines stay up while flag and enable are both set
  assign o_rdata        = r.rdata;
  assign o_waveform_out = r.wave;
  assign o_ovf_req      = r.csr[ebt_pkg::CS_OVF]  & r.ctrl0[ebt_pkg::C0_OVERFLOW_IRQ_ENABLE];
  assign o_match_a_req  = r.csr[ebt_pkg::CS_MATCH_FLAG_A] & r.ctrl0[ebt_pkg::C0_IEA];
  assign o_match_b_req  = r.csr[ebt_pkg::CS_MATCH_FLAG_B] & r.ctrl0[ebt_pkg::C0_IEB];

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_edge_off: assert property (edg_sel == ebt_pkg::EDG_OFF |-> !trg_ev)
    else $error("trigger edge seen while disabled");
  a_halt_clear: assert property (trigger_start_enable && clear && !trg_ev |=> !r.run && !tick)
    else $error("count continued after clear with trigger enabled");
  a_ones_read: assert property (i_rd && i_addr == ebt_pkg::ADDR_CTRL1 |=> o_rdata[7:5] == 3'h7 && o_rdata[1])
    else $error("unused control bits not read as one");
  a_no_clock: assert property (cks[1:0] == 2'h0 |-> !tick)
    else $error("count with no clock selected");
  a_count_step: assert property (tick && !clear && !wr_cnt |=> r.cnt == $past(r.cnt) + 8'h01)
    else $error("increment not applied");
  a_ovf_flag: assert property (ovf_ev |=> r.csr[ebt_pkg::CS_OVF] && r.cnt == ebt_pkg::RST_ZERO)
    else $error("overflow flag not set");
  a_match_flag: assert property (match_a |=> r.csr[ebt_pkg::CS_MATCH_FLAG_A])
    else $error("match a flag not set");
  a_cmp_write: assert property (wr_cmpb |-> !match_b)
    else $error("match raised during compare write");
  a_clear_wins: assert property (clear && wr_cnt |=> r.cnt == 8'h00)
    else $error("counter write beat the clear");
  a_write_wins: assert property (wr_cnt && tick && !clear |=> r.cnt == $past(i_wdata))
    else $error("increment beat the counter write");
  a_toggle_pri: assert property ((match_a && os_a == ebt_pkg::OS_TOG) |=> o_waveform_out != $past(o_waveform_out))
    else $error("toggle did not win");

endmodule : ebt_timer

//--- sim/ebt_pins.sv
// pin-side partner of the timer: trigger, clear and external clock sources
`timescale 1ns/1ps
module ebt_pins (
  // clock
  input  wire logic i_clk,
  // pins toward the timer
  output logic      o_trigger_pin,
  output logic      o_clear_input_pin,
  output logic      o_ext_clk_pin
);
  // ==========================================================
  // idle levels: all pins low until a test moves them
  initial
  begin
    o_trigger_pin     = 1'b0;
    o_clear_input_pin = 1'b0;
    o_ext_clk_pin     = 1'b0;
  end

  // new trigger level, held until the next call
  task automatic set_trigger(input logic v);
    @(posedge i_clk);
    o_trigger_pin <= v;
  endtask : set_trigger

  // clear pulse held two clocks, above the minimum pulse width
  task automatic pulse_clear();
    @(posedge i_clk);
    o_clear_input_pin <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_clear_input_pin <= 1'b0;
  endtask : pulse_clear

  // n external periods; slow halves so the synchroniser sees each level
  task automatic ext_periods(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_ext_clk_pin <= 1'b1;
      repeat (6) @(posedge i_clk);
      o_ext_clk_pin <= 1'b0;
      repeat (5) @(posedge i_clk);
    end
  endtask : ext_periods
endmodule : ebt_pins

//--- sim/ebt_timer_test.sv
// self-checking bench for the eight-bit trigger timer
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, 8'(e), 8'(g))
module ebt_timer_test;
  // ==========================================================
  // short register addresses
  localparam logic [2:0] A_CNT = ebt_pkg::ADDR_CNT;
  localparam logic [2:0] A_CA  = ebt_pkg::ADDR_CMPA;
  localparam logic [2:0] A_CB  = ebt_pkg::ADDR_CMPB;
  localparam logic [2:0] A_C0  = ebt_pkg::ADDR_CTRL0;
  localparam logic [2:0] A_C1  = ebt_pkg::ADDR_CTRL1;
  localparam logic [2:0] A_CS  = ebt_pkg::ADDR_CSR;
  // clock, reset, register port, pins
  logic       i_clk   = 1'b0;
  logic       i_rst   = 1'b1;
  logic [2:0] i_addr  = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr    = 1'b0;
  logic       i_rd    = 1'b0;
  logic [7:0] o_rdata;
  logic       trg_pin;
  logic       clr_pin;
  logic       ext_pin;
  logic       o_waveform_out;
  logic       o_ovf_req;
  logic       o_match_a_req;
  logic       o_match_b_req;
  // counters and scratch
  int         n_fail   = 0;
  int         n_checks = 0;
  int         n;
  int         k;
  logic [7:0] rv;
  // register rows: address, write value, expected read-back
  logic [18:0] reg_rows [10] = '{{A_CA, 8'h5a, 8'h5a}, {A_CB, 8'ha5, 8'ha5}, {A_CNT, 8'h33, 8'h33},
    {A_C1, 8'hff, 8'hff}, {A_C1, 8'h00, 8'he2}, {A_C0, 8'hf8, 8'hf8}, {A_CS, 8'hef, 8'h1f},
    {A_C0, 8'h00, 8'h00}, {3'h7, 8'hff, 8'h00}, {A_CS, 8'h00, 8'h10}};
  // output select rows: select b, select a, expected level after the joint match
  logic [4:0]  os_rows [8]   = '{5'h05, 5'h02, 5'h00, 5'h13, 5'h0e, 5'h17, 5'h08, 5'h19};
  // trigger rows: edge select, new pin level, counter expected to start
  logic [3:0]  trg_rows [8]  = '{4'h7, 4'h4, 4'ha, 4'h9, 4'h2, 4'h0, 4'hf, 4'hd};

  // ==========================================================
  // design and pin partner
  ebt_timer i_ebt_timer (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_trigger_pin(trg_pin), .i_clear_input_pin(clr_pin), .i_ext_clk_pin(ext_pin),
    .o_waveform_out(o_waveform_out), .o_ovf_req(o_ovf_req), .o_match_a_req(o_match_a_req),
    .o_match_b_req(o_match_b_req));
  ebt_pins i_ebt_pins (
    .i_clk(i_clk), .o_trigger_pin(trg_pin), .o_clear_input_pin(clr_pin), .o_ext_clk_pin(ext_pin));

  // 250 MHz clock
  always #2 i_clk = ~i_clk;

  // ==========================================================
  // compare, count and report
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  // one-cycle write strobe; the slave never stalls
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  // cycles until the waveform pin changes, sampled away from the edge
  task automatic wait_wave(output int c);
    logic prev;
    @(negedge i_clk);
    prev = o_waveform_out;
    c = 0;
    while (o_waveform_out === prev && c < 400)
    begin
      @(negedge i_clk);
      c++;
    end
  endtask : wait_wave
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // watchdog: tests need about 3800 cycles, cut off at 25000
  initial
  begin
    #100000;
    n_fail++;
    $display("watchdog expired");
    test_done();
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    for (k = 0; k < 10; k++)
    begin
      wr(reg_rows[k][18:16], reg_rows[k][15:8]);
      rd(reg_rows[k][18:16], rv);
      `CHK("register readback", reg_rows[k][7:0], rv);
    end
    `CHK("wave after reset", 0, o_waveform_out);
    $display("test registers done");
    // both compares at 2, cleared on a: each row ends after exactly one joint match
    wr(A_CA, 8'h02);
    wr(A_CB, 8'h02);
    for (k = 0; k < 8; k++)
    begin
      wr(A_CNT, 8'h00);
      wr(A_CS, {4'h0, os_rows[k][4:1]});
      wr(A_C0, 8'h09);
      repeat (17) @(posedge i_clk);
      wr(A_C0, 8'h00);
      @(negedge i_clk);
      `CHK("wave select", os_rows[k][0], o_waveform_out);
    end
    $display("test output select done");
    // toggle on match a, cleared on match a: four ticks per half period
    wr(A_CNT, 8'h00);
    wr(A_CA, 8'h03);
    wr(A_CS, 8'h03);
    wr(A_C0, 8'hc9);
    wait_wave(n);
    wait_wave(n);
    `CHK("toggle period", 8'h10, n + 1);
    `CHK("match a request", 1, o_match_a_req);
    `CHK("match b request", 1, o_match_b_req);
    // stop the clock but keep both enables so the clear below is seen
    wr(A_C0, 8'hc0);
    rd(A_CNT, rv);
    `CHK("count within compare", 1, rv <= 8'h03);
    rd(A_CS, rv);
    wr(A_CS, 8'h03);
    @(negedge i_clk);
    `CHK("match a request cleared", 0, o_match_a_req);
    `CHK("match b request cleared", 0, o_match_b_req);
    $display("test compare match done");
    // wrap from ff
    wr(A_CNT, 8'hfe);
    wr(A_C0, 8'h21);
    repeat (16) @(posedge i_clk);
    wr(A_C0, 8'h20);
    `CHK("overflow request", 1, o_ovf_req);
    rd(A_CS, rv);
    `CHK("overflow flag", 8'h20, rv & 8'h20);
    wr(A_CS, 8'h00);
    @(negedge i_clk);
    `CHK("overflow cleared", 0, o_ovf_req);
    $display("test overflow done");
    // every internal divider, ten periods each; the write cycles may add one
    for (k = 0; k < 6; k++)
    begin
      wr(A_CNT, 8'h00);
      wr(A_C1, 8'(k % 2));
      wr(A_C0, 8'(k / 2 + 1));
      repeat (10 * (4 << k)) @(posedge i_clk);
      wr(A_C0, 8'h00);
      rd(A_CNT, rv);
      `CHK("divided count", 1, rv >= 8'h09 && rv <= 8'h0c);
    end
    // external clock codes: none, rising, falling, both
    for (k = 4; k < 8; k++)
    begin
      wr(A_CNT, 8'h00);
      wr(A_C0, 8'(k));
      i_ebt_pins.ext_periods(4);
      repeat (8) @(posedge i_clk);
      wr(A_C0, 8'h00);
      rd(A_CNT, rv);
      `CHK("external count", (k == 4) ? 0 : (k == 7) ? 8 : 4, rv);
    end
    $display("test clock sources done");
    // clear pin while counting from 80
    wr(A_CNT, 8'h80);
    wr(A_C0, 8'h19);
    repeat (8) @(posedge i_clk);
    i_ebt_pins.pulse_clear();
    repeat (4) @(posedge i_clk);
    wr(A_C0, 8'h00);
    rd(A_CNT, rv);
    `CHK("cleared by pin", 1, rv < 8'h08);
    $display("test clear pin done");
    // trigger start, halt after each clear on match a at 5
    wr(A_C1, 8'h0c);
    wr(A_CNT, 8'h00);
    wr(A_CA, 8'h05);
    wr(A_CS, 8'h01);
    wr(A_C0, 8'h09);
    for (k = 0; k < 8; k++)
    begin
      wr(A_C1, {3'h0, trg_rows[k][3:2], 3'h4});
      repeat (40) @(posedge i_clk);
      i_ebt_pins.set_trigger(trg_rows[k][1]);
      repeat (12) @(posedge i_clk);
      rd(A_CNT, rv);
      `CHK("trigger start", trg_rows[k][0], rv != 8'h00);
    end
    // force a match a clear so the gate is closed before the pulse test
    wr(A_CNT, 8'h05);
    repeat (12) @(posedge i_clk);
    $display("test trigger done");
    // single pulse: high at match a (3), low and halt at match b (7)
    wr(A_C0, 8'h00);
    wr(A_CA, 8'h03);
    wr(A_CB, 8'h07);
    wr(A_CS, 8'h06);
    wr(A_C1, 8'h14);
    wr(A_CNT, 8'h00);
    i_ebt_pins.set_trigger(1'b1);
    wr(A_C0, 8'h11);
    repeat (8) @(posedge i_clk);
    rd(A_CNT, rv);
    `CHK("held before trigger", 0, rv);
    i_ebt_pins.set_trigger(1'b0);
    wait_wave(n);
    `CHK("pulse high", 1, o_waveform_out);
    wait_wave(n);
    `CHK("pulse width", 8'h10, n + 1);
    $display("test single pulse done");
    // reset in mid-run with the waveform driven high
    wr(A_C1, 8'h00);
    wr(A_CS, 8'h02);
    wr(A_C0, 8'h09);
    repeat (40) @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(A_C0, rv);
    `CHK("ctrl0 after reset", 8'h00, rv);
    rd(A_CNT, rv);
    `CHK("count after reset", 8'h00, rv);
    `CHK("wave after reset", 0, o_waveform_out);
    $display("test second reset done");
    test_done();
  end
endmodule : ebt_timer_test
